//--- hw/rsq_top.sv
// module: trigger scan sequencer with apb registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module rsq_top
  import rsq_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr,
  // backplane trigger pin, asynchronous
  input  wire logic                hw_trig,
  // module codes present per slot, from backplane
  input  wire logic [NSLOT*16-1:0] slot_model,
  // relay drive
  output      logic [NSEC*NCH-1:0] relay
);

  typedef struct packed {
    rsq_state_e  state;
    logic        free_run;
    logic [1:0]  src;
    logic [15:0] count;
    logic [15:0] delay;
    logic [15:0] dcnt;
    logic [15:0] pass;
    logic [6:0]  len;
    logic [6:0]  wptr;
    logic [6:0]  pos;       // next entry to close
    logic        closed;    // an entry is currently closed
    logic [6:0]  cur;       // entry currently closed
    logic [5:0]  join_m;
    logic [5:0]  scan_m;
    logic [1:0]  cfg;
    logic [3:0]  msel;
    logic [1:0]  sync;
    logic        trig_d;
    logic [31:0] rdata;
    logic        err;
    logic [NLIST*9-1:0] list;
  } rsq_top_s;

  rsq_top_s   r_reg, r_next;
  rsq_relay_if rif();

  wire logic setup = psel && !penable;
  wire logic wr    = setup && pwrite;
  wire logic rd    = setup && !pwrite;

  // decode used by read and write paths
  function automatic logic known(input logic [7:0] a);
    return a == A_CTRL || a == A_SRC || a == A_COUNT || a == A_DELAY ||
           a == A_LISTLEN || a == A_LISTWR || a == A_STATUS ||
           a == A_SECT || a == A_MODEL || a == A_NAME ||
           (a >= A_RELAY && a < A_RELAY + 8'h20);
  endfunction

  function automatic logic [8:0] entry(input rsq_top_s s,
                                       input logic [6:0] i);
    return s.list[int'(i)*9 +: 9];
  endfunction

  logic       hw_edge;
  logic       step;
  logic       accept;
  logic       swt;
  logic [8:0] e_new;
  logic [8:0] e_old;
  logic [7:0] ridx;

  assign hw_edge = r_reg.sync[1] && !r_reg.trig_d;
  assign swt     = wr && paddr == A_CTRL && pwdata[C_SWTRIG];
  assign e_new   = entry(r_reg, r_reg.pos);
  assign e_old   = entry(r_reg, r_reg.cur);
  assign ridx    = (paddr - A_RELAY) >> 2;

  // accepted trigger from the enabled source
  always_comb begin
    accept = 1'b0;
    case (rsq_src_e'(r_reg.src))
      SRC_HOLD: accept = 1'b0;
      SRC_HW:   accept = hw_edge;
      SRC_CMD:  accept = wr && paddr == A_CTRL && pwdata[C_SWTRIG];
      SRC_IMM:  accept = 1'b1;
      default:  accept = 1'b0;
    endcase
  end

  // sequencer, registers and relay commands
  always_comb begin
    r_next          = r_reg;
    r_next.sync     = {r_reg.sync[0], hw_trig};
    r_next.trig_d   = r_reg.sync[1];
    rif.cmd         = '0;
    rif.join_mask   = r_reg.join_m;
    rif.scan_mask   = r_reg.scan_m;
    step            = 1'b0;

    case (r_reg.state)
      ST_IDLE: begin
        step = 1'b0;
      end
      ST_ARMED: begin
        if (swt) begin
          step = 1'b1;
        end else if (accept && r_reg.src != SRC_CMD) begin
          if (r_reg.delay == '0) begin
            step = 1'b1;
          end else begin
            r_next.dcnt  = r_reg.delay;
            r_next.state = ST_WAIT;
          end
        end else if (accept) begin
          step = 1'b1;
        end
      end
      ST_WAIT: begin
        if (swt || r_reg.dcnt == 16'h0001) begin
          step         = 1'b1;
          r_next.state = ST_ARMED;
        end else begin
          r_next.dcnt = r_reg.dcnt - 16'h0001;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase

    if (step) begin
      // open previous then close next; first step has nothing open
      rif.cmd.open_one  = r_reg.closed;
      rif.cmd.open_sec  = e_old[8:6];
      rif.cmd.open_ch   = e_old[5:0];
      if (!r_reg.free_run && r_reg.pos == '0 &&
          r_reg.pass == r_reg.count && r_reg.closed) begin
        rif.cmd.close_one = 1'b0;
        r_next.closed     = 1'b0;
        r_next.state      = ST_IDLE;
      end else begin
        rif.cmd.close_one = 1'b1;
        rif.cmd.close_sec = e_new[8:6];
        rif.cmd.close_ch  = e_new[5:0];
        r_next.closed     = 1'b1;
        r_next.cur        = r_reg.pos;
        if (r_reg.pos + 7'h01 >= r_reg.len) begin
          r_next.pos  = '0;
          r_next.pass = r_reg.pass + 16'h0001;
        end else begin
          r_next.pos  = r_reg.pos + 7'h01;
        end
      end
    end

    // apb writes take effect in the setup cycle, zero wait
    if (wr) begin
      // error flag stands until the next setup, set or cleared here
      r_next.err = !known(paddr);
      case (paddr)
        A_CTRL: begin
          if (pwdata[C_ARM_CNT] && r_reg.state == ST_IDLE
              && r_reg.len != '0) begin
            r_next.state    = ST_ARMED;
            r_next.free_run = 1'b0;
            r_next.pos      = '0;
            // passes completed so far; done once it equals count
            r_next.pass     = 16'h0000;
          end
          if (pwdata[C_ARM_FREE] && r_reg.state == ST_IDLE
              && r_reg.len != '0) begin
            r_next.state    = ST_ARMED;
            r_next.free_run = 1'b1;
            r_next.pos      = '0;
            r_next.pass     = 16'h0000;
          end
          if (pwdata[C_HALT]) begin
            rif.cmd.open_one  = r_reg.closed;
            rif.cmd.open_sec  = e_old[8:6];
            rif.cmd.open_ch   = e_old[5:0];
            rif.cmd.close_one = 1'b0;
            r_next.closed     = 1'b0;
            r_next.state      = ST_IDLE;
          end
          if (pwdata[C_CLOSE]) begin
            rif.cmd.close_one = 1'b1;
            rif.cmd.close_sec = pwdata[18:16];
            rif.cmd.close_ch  = pwdata[13:8];
          end
          if (pwdata[C_CONFIG]) begin
            rif.cmd.open_all = 1'b1;
            rif.cmd.sec_mask = pwdata[29:24];
            r_next.cfg       = pwdata[21:20];
          end
          if (pwdata[C_JOIN]) begin
            r_next.join_m = r_reg.join_m | pwdata[29:24];
          end
          if (pwdata[C_DISJOIN]) begin
            r_next.join_m = '0;
          end
        end
        A_SRC:     r_next.src   = pwdata[1:0];
        A_COUNT:   r_next.count = pwdata[15:0];
        A_DELAY:   r_next.delay = pwdata[15:0];
        A_LISTLEN: begin
          r_next.len  = pwdata[6:0];
          r_next.wptr = '0;
        end
        A_LISTWR: begin
          if (r_reg.wptr < 7'(NLIST)) begin
            r_next.list[int'(r_reg.wptr)*9 +: 9] = pwdata[8:0];
            r_next.wptr = r_reg.wptr + 7'h01;
          end
        end
        A_SECT:    r_next.scan_m = pwdata[5:0];
        A_MODEL:   r_next.msel   = pwdata[3:0];
        default:   r_next.err    = !known(paddr);
      endcase
    end

    // read data captured in setup, presented in access
    if (rd) begin
      r_next.err   = !known(paddr);
      r_next.rdata = '0;
      case (paddr)
        A_SRC:     r_next.rdata = {30'h0, r_reg.src};
        A_COUNT:   r_next.rdata = {16'h0, r_reg.count};
        A_DELAY:   r_next.rdata = {16'h0, r_reg.delay};
        A_LISTLEN: r_next.rdata = {25'h0, r_reg.len};
        A_STATUS:  r_next.rdata = {r_reg.pass, 1'b0, r_reg.pos,
                                   3'h0, r_reg.closed,
                                   r_reg.free_run, 1'b0, r_reg.state};
        A_SECT:    r_next.rdata = {18'h0, r_reg.cfg, r_reg.join_m,
                                   r_reg.scan_m};
        // carrier first then slots to the right
        A_MODEL:   r_next.rdata = (r_reg.msel < 4'(NSLOT)) ?
          {16'h0, slot_model[int'(r_reg.msel)*16 +: 16]} : 32'h0;
        // default name index is slot position plus one
        A_NAME:    r_next.rdata = {28'h0, r_reg.msel + 4'h1};
        default: begin
          if (paddr >= A_RELAY && paddr < A_RELAY + 8'h20 &&
              ridx < 8'h08) begin
            r_next.rdata = relay[int'(ridx)*32 +: 32];
          end
        end
      endcase
    end
  end

  // single state register, reset leaves idle and defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg       <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.count <= RST_COUNT;
      r_reg.delay <= RST_DELAY;
    end else begin
      r_reg <= r_next;
    end
  end

  // one access cycle, never stretched
  assign pready  = 1'b1;
  assign prdata  = r_reg.rdata;
  assign pslverr = r_reg.err;

  rsq_relay_bank u_bank (
    .clk   (clk),
    .nrst  (nrst),
    .rif   (rif.bank),
    .relay (relay)
  );

endmodule

//--- hw/rsq_pkg.sv
// package: constants, types and register map of the relay scan sequencer
// Behaviour
// - counted arm moves idle to armed
// - trigger closes next relay, opens previous
// - counted passes done returns to idle
// - idle ignores triggers, relays unchanged
// - reset leaves sequencer idle
// - free arm needs defined scan list
// - free trigger opens current, closes next
// - free mode runs until halt command
// - halt opens closed relay, then idle
// - suspend source ignores all hardware triggers
// - software trigger overrides suspend, skips delay
// - first trigger only closes first relay
// - trigger after last pass entry idles
// - immediate source steps list until halt, or until counted passes are done
// - joined close opens all joined scan sections first
// - four joined 40-channel sections act 160-channel
// - scan mode keeps one relay per section
// - model query returns carrier then slots
// - default names sequential from carrier
// - join links commons of listed sections
// - configuration change opens named sections' relays
package rsq_pkg;

  localparam int NSEC  = 6;   // sections per module
  localparam int NCH   = 40;  // relays per section
  localparam int NLIST = 80;  // scan list depth
  localparam int NSLOT = 12;  // carrier plus following slots

  // apb register offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_SRC     = 8'h04;
  localparam logic [7:0] A_COUNT   = 8'h08;
  localparam logic [7:0] A_DELAY   = 8'h0C;
  localparam logic [7:0] A_LISTLEN = 8'h10;
  localparam logic [7:0] A_LISTWR  = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h18;
  localparam logic [7:0] A_SECT    = 8'h1C;
  localparam logic [7:0] A_RELAY   = 8'h20;
  localparam logic [7:0] A_MODEL   = 8'h40;
  localparam logic [7:0] A_NAME    = 8'h44;

  // ctrl bit positions (write one pulses)
  localparam int C_ARM_CNT  = 0;
  localparam int C_ARM_FREE = 1;
  localparam int C_HALT     = 2;
  localparam int C_SWTRIG   = 3;
  localparam int C_CLOSE    = 4;
  localparam int C_CONFIG   = 5;
  localparam int C_JOIN     = 6;
  localparam int C_DISJOIN  = 7;

  // reset values
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [15:0] RST_DELAY = 16'h0000;

  typedef enum logic [1:0] {
    SRC_HOLD, SRC_HW, SRC_CMD, SRC_IMM
  } rsq_src_e;

  typedef enum logic [1:0] {
    ST_IDLE, ST_ARMED, ST_WAIT
  } rsq_state_e;

  // one step request passed to the relay bank
  typedef struct packed {
    logic       open_all;     // open every relay of masked sections
    logic [5:0] sec_mask;
    logic       open_one;
    logic [2:0] open_sec;
    logic [5:0] open_ch;
    logic       close_one;
    logic [2:0] close_sec;
    logic [5:0] close_ch;
  } rsq_cmd_s;

endpackage

//--- hw/rsq_relay_if.sv
// interface: relay bank command carrier
`timescale 1ns/1ps
interface rsq_relay_if;
  import rsq_pkg::*;
  rsq_cmd_s   cmd;
  logic [5:0] join_mask;
  logic [5:0] scan_mask;
  modport seq  (output cmd, output join_mask, output scan_mask);
  modport bank (input cmd, input join_mask, input scan_mask);
endinterface

//--- hw/rsq_relay_bank.sv
// module: relay state bank with scan and join exclusion
`timescale 1ns/1ps
module rsq_relay_bank
  import rsq_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // command side
  rsq_relay_if.bank              rif,
  // relay drive
  output      logic [NSEC*NCH-1:0] relay
);

  typedef struct packed {
    logic [NSEC*NCH-1:0] relay;
  } rsq_bank_s;

  rsq_bank_s st_reg, st_next;

  // opens, then exclusion clear, then close: later wins in one cycle
  always_comb begin
    st_next = st_reg;
    if (rif.cmd.open_all) begin
      for (int s = 0; s < NSEC; s++) begin
        if (rif.cmd.sec_mask[s]) begin
          st_next.relay[s*NCH +: NCH] = '0;
        end
      end
    end
    if (rif.cmd.open_one) begin
      st_next.relay[int'(rif.cmd.open_sec)*NCH + int'(rif.cmd.open_ch)]
        = 1'b0;
    end
    if (rif.cmd.close_one) begin
      for (int s = 0; s < NSEC; s++) begin
        // scan sections hold one relay; joined ones act as one scanner
        if (s == int'(rif.cmd.close_sec) && rif.scan_mask[s]) begin
          st_next.relay[s*NCH +: NCH] = '0;
        end
        if (rif.join_mask[rif.cmd.close_sec] && rif.join_mask[s]
            && rif.scan_mask[s]) begin
          st_next.relay[s*NCH +: NCH] = '0;
        end
      end
      st_next.relay[int'(rif.cmd.close_sec)*NCH + int'(rif.cmd.close_ch)]
        = 1'b1;
    end
  end

  // reset opens every relay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign relay = st_reg.relay;

endmodule

//--- tb/rsq_properties.sv
// checker: bus and relay behaviour of the scan sequencer
`timescale 1ns/1ps
module rsq_properties
  import rsq_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // pins
  input wire logic                hw_trig,
  input wire logic [NSLOT*16-1:0] slot_model,
  input wire logic [NSEC*NCH-1:0] relay
);
  logic       setup;
  logic       ctrl_seen;
  logic [3:0] slot_sel;

  assign setup = psel && !penable;

  // helper: first control write seen, slot last selected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_seen <= 1'b0;
      slot_sel  <= 4'h0;
    end else if (setup && pwrite) begin
      if (paddr == A_CTRL) ctrl_seen <= 1'b1;
      if (paddr == A_MODEL) slot_sel <= pwdata[3:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // setup phases of the two transfer kinds
  sequence ctrl_wr(int b);
    setup && pwrite && paddr == A_CTRL && pwdata[b];
  endsequence
  sequence rd_of(logic [7:0] a);
    setup && !pwrite && paddr == a;
  endsequence

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (setup && paddr >= 8'h48 |=> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (rd_of(A_STATUS) |=> !pslverr)
    else $error("error on mapped read");
  a_read_holds: assert property (psel && penable |=>
    $stable(prdata) && $stable(pslverr))
    else $error("read answer moved after access");
  a_reset_open: assert property ($rose(nrst) |-> relay == '0)
    else $error("relay closed after reset");
  a_idle_quiet: assert property (!ctrl_seen |-> $stable(relay))
    else $error("relay moved while idle");
  a_config_opens: assert property (ctrl_wr(C_CONFIG) ##0 pwdata[24]
    |-> ##[1:4] relay[NCH-1:0] == '0)
    else $error("configured section not opened");
  a_halt_opens: assert property (ctrl_wr(C_HALT) ##0
    ($countones(relay) <= 1) |-> ##[1:6] relay == '0)
    else $error("halt left a relay closed");
  a_model_read: assert property (rd_of(A_MODEL) |=>
    prdata[15:0] == slot_model[slot_sel*16 +: 16])
    else $error("wrong model code");
  a_name_read: assert property (rd_of(A_NAME) |=>
    prdata == 32'(slot_sel) + 32'h1)
    else $error("wrong default name");
endmodule

bind rsq_top rsq_properties i_rsq_properties (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_trig(hw_trig), .slot_model(slot_model), .relay(relay));

//--- tb/rsq_host.sv
// bus partner: apb master issuing register transfers
`timescale 1ns/1ps
module rsq_host (
  // clock
  input  wire logic        clk,
  // apb master
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [7:0]  paddr,
  output      logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic hung;

  // quiet bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
  end

  // one transfer; request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hung = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- tb/relay_scan_trigger_sequencer_test.sv
// testbench: scan sequencer driven over apb
`timescale 1ns/1ps
module relay_scan_trigger_sequencer_test;
  import rsq_pkg::*;
  localparam int W = NSEC*NCH;
  logic                clk;
  logic                nrst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                hw_trig;
  logic [NSLOT*16-1:0] slot_model;
  logic [W-1:0]        relay;
  logic [31:0]         q;
  logic                e;
  logic [8:0]          lst [3];
  int                  fails;
  int                  tests_run;

  // design and bus partner
  rsq_top i_rsq_top (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trig(hw_trig), .slot_model(slot_model), .relay(relay));
  rsq_host i_rsq_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // expected relay word for one list entry
  function automatic logic [W-1:0] onehot(input logic [8:0] ent);
    onehot = '0;
    onehot[ent[8:6]*NCH + ent[5:0]] = 1'b1;
  endfunction

  task automatic chk(input string nm, input logic [W-1:0] ex,
                     input logic [W-1:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_rsq_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    i_rsq_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // bounded poll; hardware steps arrive a few cycles late
  task automatic wait_relay(input string nm, input logic [W-1:0] ex);
    int n;
    n = 0;
    while (relay !== ex && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk(nm, ex, relay);
  endtask

  task automatic pulse();
    @(posedge clk);
    hw_trig <= 1'b1;
    repeat (3) @(posedge clk);
    hw_trig <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    int k;
    logic b;
    clk = 1'b0;
    nrst = 1'b0;
    hw_trig = 1'b0;
    k = $urandom(87);
    for (k = 0; k < NSLOT; k++) slot_model[k*16 +: 16] = 16'($urandom());
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(A_STATUS);
    chk("reset state", 2'b00, q[1:0]);
    rd(A_COUNT);
    chk("count reset", RST_COUNT, q[15:0]);
    // idle: pin and software trigger both ignored
    wr(A_SRC, 32'h1);
    pulse();
    wr(A_CTRL, 32'h8);
    repeat (12) @(posedge clk);
    chk("idle relays", '0, relay);
    wr(A_CTRL, 32'h2);
    rd(A_STATUS);
    chk("arm empty list", 2'b00, q[1:0]);
    $display("done: idle");
    // counted scan, two passes, hold source
    wr(A_LISTLEN, 32'd3);
    for (k = 0; k < 3; k++) begin
      lst[k] = {3'(k*2), 6'($urandom_range(NCH-1))};
      wr(A_LISTWR, {23'h0, lst[k]});
    end
    wr(A_COUNT, 32'd2);
    wr(A_SRC, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(A_STATUS);
    chk("counted armed", 2'b01, q[1:0]);
    pulse();
    repeat (12) @(posedge clk);
    chk("hold ignores pin", '0, relay);
    for (k = 0; k < 6; k++) begin
      wr(A_CTRL, 32'h8);
      wait_relay("counted step", onehot(lst[k % 3]));
    end
    wr(A_CTRL, 32'h8);
    wait_relay("counted end", '0);
    rd(A_STATUS);
    chk("counted idle", 2'b00, q[1:0]);
    $display("done: counted");
    // pin source with delay; software step skips it
    wr(A_DELAY, 32'd40);
    wr(A_SRC, 32'h1);
    wr(A_CTRL, 32'h1);
    pulse();
    repeat (10) @(posedge clk);
    chk("delay holds", '0, relay);
    wait_relay("delayed step", onehot(lst[0]));
    wr(A_CTRL, 32'h8);
    repeat (4) @(posedge clk);
    chk("soft skips delay", onehot(lst[1]), relay);
    wr(A_CTRL, 32'h4);
    wait_relay("halt opens", '0);
    $display("done: delay");
    // free run on immediate source until halt
    wr(A_DELAY, 32'h0);
    wr(A_SRC, 32'h3);
    wr(A_CTRL, 32'h2);
    b = 1'b0;
    k = 0;
    repeat (200) begin
      @(posedge clk);
      if ($countones(relay) > 1) b = 1'b1;
      if (relay === onehot(lst[2])) k++;
    end
    chk("one closed", 1'b0, b);
    chk("keeps stepping", 1'b1, k > 0);
    wr(A_CTRL, 32'h4);
    wait_relay("free halt", '0);
    rd(A_STATUS);
    chk("free idle", 2'b00, q[1:0]);
    // trigger-command source steps the counted scan
    wr(A_SRC, 32'h2);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h8);
    wait_relay("cmd source step", onehot(lst[0]));
    wr(A_CTRL, 32'h4);
    wait_relay("cmd source halt", '0);
    $display("done: free");
    // direct close, configure opens, join commons
    wr(A_CTRL, 32'h0000_0510);
    wait_relay("direct close", onehot(9'h005));
    wr(A_CTRL, 32'h0110_0020);
    wait_relay("config opens", '0);
    wr(A_CTRL, 32'h0F00_0040);
    rd(A_SECT);
    chk("join mask", 6'h0F, q[11:6]);
    $display("done: sections");
    // model codes and default names per slot
    for (k = 0; k < NSLOT; k++) begin
      wr(A_MODEL, k);
      rd(A_MODEL);
      chk("model code", slot_model[k*16 +: 16], q[15:0]);
      rd(A_NAME);
      chk("default name", k + 1, q);
    end
    rd(8'h80);
    chk("unmapped err", 1'b1, e);
    chk("bus hang", 1'b0, i_rsq_host.hung);
    $display("done: query");
    wrap_up();
  end
endmodule
